// [rtl/nrps_cycle_if.sv]
// one bus cycle request between sequencer and strobe engine
interface nrps_cycle_if;
	import nrps_pkg::*;
	logic req;
	nrps_cycle_type kind;
	logic [7:0] wdata;
	logic done;
	logic [7:0] rdata;
	modport seq(output req, output kind, output wdata, input done, input rdata);
	modport eng(input req, input kind, input wdata, output done, output rdata);
endinterface

// [rtl/nrps_defines.svh]
// constants of the nand read/program sequencer host
`ifndef NRPS_DEFINES_SVH
`define NRPS_DEFINES_SVH
`define NRPS_CMD_READ 8'h00
`define NRPS_CMD_READ_GO 8'h30
`define NRPS_CMD_CACHE_NEXT 8'h31
`define NRPS_CMD_CACHE_LAST 8'h3F
`define NRPS_CMD_MP_READ 8'h60
`define NRPS_CMD_PROG_IN 8'h80
`define NRPS_CMD_PROG_IN2 8'h81
`define NRPS_CMD_COL_CHG 8'h85
`define NRPS_CMD_PROG_GO 8'h10
`define NRPS_CMD_PROG_MID 8'h11
`define NRPS_CMD_STATUS 8'h70
`define NRPS_CMD_RESET 8'hFF
`define NRPS_ADDR_CYCLES 3'h5
`define NRPS_COL_CYCLES 3'h2
`define NRPS_STROBE_LOW 2'h2
`define NRPS_STROBE_HIGH 2'h2
`define NRPS_FAIL_BIT 0
`define NRPS_IN_BLOCK_BITS 6
`endif

// [rtl/nrps_host.sv]
// host sequencer for nand page read and page program command chains
`include "nrps_defines.svh"
module nrps_host (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// user command port
	input wire logic op_valid,
	output logic op_ready,
	input wire nrps_pkg::nrps_op_type op_code,
	input wire logic [12:0] op_column,
	input wire logic [16:0] op_page,
	input wire logic [16:0] op_page2,
	input wire logic [7:0] op_wdata,
	input wire logic op_skip_read_cmd,
	output logic op_done,
	output logic [7:0] op_rdata,
	output logic op_error,
	output logic any_page_failed,
	// nand pins
	output logic cle,
	output logic ale,
	output logic chip_enable_n,
	output logic write_strobe_n,
	output logic read_strobe_n,
	output logic write_protect_n,
	input wire logic ready_busy_n,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic io_oe
);
	import nrps_pkg::*;
	typedef enum logic [6:0] {
		NRPS_SQ_IDLE = 7'b0000001,
		NRPS_SQ_CMD1 = 7'b0000010,
		NRPS_SQ_ADDR = 7'b0000100,
		NRPS_SQ_CMD2 = 7'b0001000,
		NRPS_SQ_DATA = 7'b0010000,
		NRPS_SQ_WAIT = 7'b0100000,
		NRPS_SQ_DONE = 7'b1000000
	} nrps_sq_type;
	typedef struct packed {
		nrps_sq_type st;
		nrps_op_type op;
		logic [7:0] cmd1;
		logic [7:0] cmd2;
		logic has_cmd2;
		logic [2:0] acnt;
		logic [2:0] alen;
		logic [12:0] col;
		logic [16:0] page;
		logic [16:0] page2;
		logic second;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic issued;
		logic wait_rb;
		logic mp_prog_open;
		logic [10:0] cache_block;
		logic cache_open;
		logic err;
		logic done;
		logic fail;
		logic wp_n;
	} nrps_hstate_type;
	nrps_hstate_type h_q, h_d;
	nrps_cycle_if cyc ();
	// byte of the five-cycle address for cycle index i
	function automatic logic [7:0] addr_byte(input logic [2:0] i, input logic [12:0] c,
		input logic [16:0] p);
		case (i)
			3'h0: addr_byte = c[7:0];
			3'h1: addr_byte = {3'h0, c[12:8]};
			3'h2: addr_byte = p[7:0];
			3'h3: addr_byte = p[15:8];
			3'h4: addr_byte = {7'h00, p[16]};
			default: addr_byte = 8'h00;
		endcase
	endfunction
	function automatic logic [10:0] block_of(input logic [16:0] p);
		block_of = p[16:`NRPS_IN_BLOCK_BITS];
	endfunction
	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		h_d = h_q;
		h_d.done = 1'b0;
		h_d.issued = 1'b0;
		cyc.req = 1'b0;
		cyc.kind = NRPS_CY_CMD;
		cyc.wdata = h_q.cmd1;
		case (h_q.st)
			NRPS_SQ_IDLE: begin
				if (op_valid) begin
					h_d.op = op_code;
					h_d.col = op_column;
					h_d.page = op_page;
					h_d.page2 = op_page2;
					h_d.wdata = op_wdata;
					h_d.second = 1'b0;
					h_d.acnt = 3'h0;
					h_d.alen = `NRPS_ADDR_CYCLES;
					h_d.has_cmd2 = 1'b0;
					h_d.wait_rb = 1'b0;
					h_d.err = 1'b0;
					h_d.st = NRPS_SQ_CMD1;
					case (op_code)
						NRPS_OP_READ: begin
							h_d.cmd1 = `NRPS_CMD_READ;
							h_d.cmd2 = `NRPS_CMD_READ_GO;
							h_d.has_cmd2 = 1'b1;
							h_d.wait_rb = 1'b1;
							h_d.cache_block = block_of(op_page);
							h_d.cache_open = 1'b1;
							if (op_skip_read_cmd)
								h_d.st = NRPS_SQ_ADDR;
						end
						NRPS_OP_CACHE_NEXT, NRPS_OP_CACHE_LAST: begin
							h_d.cmd1 = (op_code == NRPS_OP_CACHE_NEXT) ?
								`NRPS_CMD_CACHE_NEXT : `NRPS_CMD_CACHE_LAST;
							h_d.alen = 3'h0;
							h_d.wait_rb = 1'b1;
							// a block change must restart with a normal read
							if (!h_q.cache_open || block_of(op_page) != h_q.cache_block) begin
								h_d.err = 1'b1;
								h_d.st = NRPS_SQ_DONE;
							end else if (op_code == NRPS_OP_CACHE_LAST) begin
								h_d.cache_open = 1'b0;
							end
						end
						NRPS_OP_MP_READ: begin
							h_d.cmd1 = `NRPS_CMD_MP_READ;
							h_d.cmd2 = `NRPS_CMD_READ_GO;
							h_d.has_cmd2 = 1'b1;
							h_d.wait_rb = 1'b1;
							h_d.wp_n = 1'b1;
							h_d.cache_open = 1'b0;
							// one block per district, same in-block page
							if (op_page[`NRPS_IN_BLOCK_BITS-1:0] !=
								op_page2[`NRPS_IN_BLOCK_BITS-1:0] ||
								op_page[`NRPS_IN_BLOCK_BITS] ==
								op_page2[`NRPS_IN_BLOCK_BITS]) begin
								h_d.err = 1'b1;
								h_d.st = NRPS_SQ_DONE;
							end
						end
						NRPS_OP_PROGRAM: begin
							h_d.cmd1 = h_q.mp_prog_open ? `NRPS_CMD_PROG_IN2 :
								`NRPS_CMD_PROG_IN;
							h_d.alen = `NRPS_ADDR_CYCLES;
							h_d.st = NRPS_SQ_CMD1;
						end
						NRPS_OP_COL_CHANGE: begin
							h_d.cmd1 = `NRPS_CMD_COL_CHG;
							h_d.alen = `NRPS_COL_CYCLES;
						end
						NRPS_OP_WRITE_DATA, NRPS_OP_READ_DATA: begin
							h_d.st = NRPS_SQ_DATA;
						end
						NRPS_OP_MP_PROGRAM: begin
							h_d.cmd1 = h_q.mp_prog_open ? `NRPS_CMD_PROG_GO :
								`NRPS_CMD_PROG_MID;
							h_d.alen = 3'h0;
							h_d.wait_rb = 1'b1;
							h_d.mp_prog_open = !h_q.mp_prog_open;
						end
						NRPS_OP_STATUS: begin
							h_d.cmd1 = `NRPS_CMD_STATUS;
							h_d.alen = 3'h0;
						end
						default: begin
							h_d.cmd1 = `NRPS_CMD_RESET;
							h_d.alen = 3'h0;
							h_d.wait_rb = 1'b1;
							h_d.mp_prog_open = 1'b0;
							h_d.cache_open = 1'b0;
						end
					endcase
					// only status, reset, write data, column change or 10h may sit between 11h and 81h
					if (h_q.mp_prog_open && op_code != NRPS_OP_STATUS &&
						op_code != NRPS_OP_RESET && op_code != NRPS_OP_PROGRAM &&
						op_code != NRPS_OP_WRITE_DATA && op_code != NRPS_OP_COL_CHANGE &&
						op_code != NRPS_OP_MP_PROGRAM) begin
						h_d.err = 1'b1;
						h_d.st = NRPS_SQ_DONE;
						h_d.mp_prog_open = 1'b1;
						// a refused op leaves the read chain as it was
						h_d.cache_open = h_q.cache_open;
						h_d.cache_block = h_q.cache_block;
					end
				end
			end
			NRPS_SQ_CMD1: begin
				cyc.req = !h_q.issued;
				h_d.issued = !cyc.done;
				cyc.wdata = h_q.cmd1;
				if (cyc.done)
					h_d.st = (h_q.alen != 3'h0) ? NRPS_SQ_ADDR : NRPS_SQ_DATA;
				if (cyc.done && h_q.alen == 3'h0)
					h_d.st = (h_q.op == NRPS_OP_STATUS) ? NRPS_SQ_DATA :
						(h_q.wait_rb ? NRPS_SQ_WAIT : NRPS_SQ_DONE);
			end
			NRPS_SQ_ADDR: begin
				cyc.req = !h_q.issued;
				h_d.issued = !cyc.done;
				cyc.kind = NRPS_CY_ADDR;
				cyc.wdata = addr_byte(h_q.acnt, h_q.col, h_q.second ? h_q.page2 : h_q.page);
				if (cyc.done) begin
					h_d.acnt = h_q.acnt + 3'h1;
					if (h_q.acnt + 3'h1 == h_q.alen) begin
						h_d.acnt = 3'h0;
						if (h_q.op == NRPS_OP_MP_READ && !h_q.second) begin
							h_d.second = 1'b1;
							h_d.st = NRPS_SQ_CMD1;
						end else if (h_q.has_cmd2) begin
							h_d.st = NRPS_SQ_CMD2;
						end else begin
							h_d.st = NRPS_SQ_DONE;
						end
					end
				end
			end
			NRPS_SQ_CMD2: begin
				cyc.req = !h_q.issued;
				h_d.issued = !cyc.done;
				cyc.wdata = h_q.cmd2;
				if (cyc.done)
					h_d.st = NRPS_SQ_WAIT;
			end
			NRPS_SQ_DATA: begin
				cyc.req = !h_q.issued;
				h_d.issued = !cyc.done;
				cyc.kind = (h_q.op == NRPS_OP_WRITE_DATA) ? NRPS_CY_DIN : NRPS_CY_DOUT;
				cyc.wdata = h_q.wdata;
				if (cyc.done) begin
					h_d.rdata = cyc.rdata;
					if (h_q.op == NRPS_OP_STATUS)
						h_d.fail = cyc.rdata[`NRPS_FAIL_BIT];
					h_d.st = NRPS_SQ_DONE;
				end
			end
			NRPS_SQ_WAIT: begin
				// strobes stay high until the device is ready
				if (ready_busy_n)
					h_d.st = NRPS_SQ_DONE;
			end
			NRPS_SQ_DONE: begin
				h_d.done = 1'b1;
				h_d.st = NRPS_SQ_IDLE;
			end
			default: h_d.st = NRPS_SQ_IDLE;
		endcase
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			h_q <= '{st: NRPS_SQ_IDLE, op: NRPS_OP_RESET, cmd1: 8'h00, cmd2: 8'h00,
				has_cmd2: 1'b0, acnt: 3'h0, alen: 3'h0, col: 13'h0000, page: 17'h00000,
				page2: 17'h00000, second: 1'b0, wdata: 8'h00, rdata: 8'h00, issued: 1'b0,
				wait_rb: 1'b0, mp_prog_open: 1'b0, cache_block: 11'h000, cache_open: 1'b0,
				err: 1'b0, done: 1'b0, fail: 1'b0, wp_n: 1'b1};
		end else begin
			h_q <= h_d;
		end
	end
	// ----------------------------------------------------------------
	// pins and outputs
	// ----------------------------------------------------------------
	nrps_strobe u_strobe (
		.mclk(mclk),
		.reset(reset),
		.cyc(cyc.eng),
		.cle(cle),
		.ale(ale),
		.write_strobe_n(write_strobe_n),
		.read_strobe_n(read_strobe_n),
		.io_in(io_in),
		.io_out(io_out),
		.io_oe(io_oe)
	);
	assign op_ready = (h_q.st == NRPS_SQ_IDLE);
	assign op_done = h_q.done;
	assign op_rdata = h_q.rdata;
	assign op_error = h_q.err;
	assign any_page_failed = h_q.fail;
	assign chip_enable_n = (h_q.st == NRPS_SQ_IDLE);
	assign write_protect_n = h_q.wp_n;
endmodule

// [rtl/nrps_pkg.sv]
// types of the nand read/program sequencer host
package nrps_pkg;
	typedef enum logic [3:0] {
		NRPS_OP_READ = 4'h0,
		NRPS_OP_CACHE_NEXT = 4'h1,
		NRPS_OP_CACHE_LAST = 4'h2,
		NRPS_OP_MP_READ = 4'h3,
		NRPS_OP_PROGRAM = 4'h4,
		NRPS_OP_MP_PROGRAM = 4'h5,
		NRPS_OP_STATUS = 4'h6,
		NRPS_OP_RESET = 4'h7,
		NRPS_OP_READ_DATA = 4'h8,
		NRPS_OP_WRITE_DATA = 4'h9,
		NRPS_OP_COL_CHANGE = 4'hA
	} nrps_op_type;
	typedef enum logic [1:0] {
		NRPS_CY_CMD = 2'h0,
		NRPS_CY_ADDR = 2'h1,
		NRPS_CY_DIN = 2'h2,
		NRPS_CY_DOUT = 2'h3
	} nrps_cycle_type;
endpackage

// [rtl/nrps_strobe.sv]
// strobe engine: one command, address or data cycle on the nand pins
`include "nrps_defines.svh"
module nrps_strobe (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// cycle request
	nrps_cycle_if.eng cyc,
	// nand pins
	output logic cle,
	output logic ale,
	output logic write_strobe_n,
	output logic read_strobe_n,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic io_oe
);
	import nrps_pkg::*;
	typedef enum logic [2:0] {
		NRPS_ST_IDLE = 3'b001,
		NRPS_ST_LOW = 3'b010,
		NRPS_ST_HIGH = 3'b100
	} nrps_sst_type;
	typedef struct packed {
		nrps_sst_type st;
		logic [1:0] cnt;
		nrps_cycle_type kind;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
		logic [7:0] dout;
		logic oe;
		logic [7:0] rdata;
		logic done;
	} nrps_sstate_type;
	nrps_sstate_type s_q, s_d;
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		case (s_q.st)
			NRPS_ST_IDLE: begin
				if (cyc.req) begin
					s_d.st = NRPS_ST_LOW;
					s_d.kind = cyc.kind;
					s_d.cnt = `NRPS_STROBE_LOW;
					s_d.cle = (cyc.kind == NRPS_CY_CMD);
					s_d.ale = (cyc.kind == NRPS_CY_ADDR);
					s_d.dout = cyc.wdata;
					s_d.oe = (cyc.kind != NRPS_CY_DOUT);
					s_d.we_n = (cyc.kind == NRPS_CY_DOUT);
					s_d.re_n = (cyc.kind != NRPS_CY_DOUT);
				end
			end
			NRPS_ST_LOW: begin
				s_d.cnt = s_q.cnt - 2'h1;
				if (s_q.cnt == 2'h1) begin
					// rising strobe edge latches into the device
					s_d.we_n = 1'b1;
					s_d.re_n = 1'b1;
					if (s_q.kind == NRPS_CY_DOUT)
						s_d.rdata = io_in;
					s_d.st = NRPS_ST_HIGH;
					s_d.cnt = `NRPS_STROBE_HIGH;
				end
			end
			NRPS_ST_HIGH: begin
				s_d.cnt = s_q.cnt - 2'h1;
				if (s_q.cnt == 2'h1) begin
					s_d.cle = 1'b0;
					s_d.ale = 1'b0;
					s_d.oe = 1'b0;
					s_d.done = 1'b1;
					s_d.st = NRPS_ST_IDLE;
				end
			end
			default: s_d.st = NRPS_ST_IDLE;
		endcase
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			s_q <= '{st: NRPS_ST_IDLE, cnt: 2'h0, kind: NRPS_CY_CMD, cle: 1'b0, ale: 1'b0,
				we_n: 1'b1, re_n: 1'b1, dout: 8'h00, oe: 1'b0, rdata: 8'h00, done: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end
	assign cle = s_q.cle;
	assign ale = s_q.ale;
	assign write_strobe_n = s_q.we_n;
	assign read_strobe_n = s_q.re_n;
	assign io_out = s_q.dout;
	assign io_oe = s_q.oe;
	assign cyc.done = s_q.done;
	assign cyc.rdata = s_q.rdata;
endmodule

// [verification/nrps_host_asserts.sv]
// port checks for the nand host sequencer
module nrps_host_asserts (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// user side
	input wire logic op_ready,
	input wire logic op_done,
	// nand pins
	input wire logic cle,
	input wire logic ale,
	input wire logic chip_enable_n,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic write_protect_n,
	input wire logic ready_busy_n,
	input wire logic io_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);
	latch_excl_a: assert property (!(cle && ale)) else $error("cle and ale high together");
	strobe_excl_a: assert property (write_strobe_n || read_strobe_n) else $error("both low");
	busy_quiet_a: assert property (
		!ready_busy_n && !chip_enable_n |-> write_strobe_n && read_strobe_n)
		else $error("strobe while busy");
	write_pulse_a: assert property (
		$fell(write_strobe_n) |=> !write_strobe_n ##1 write_strobe_n [*2])
		else $error("write strobe shape wrong");
	read_pulse_a: assert property (
		$fell(read_strobe_n) |=> !read_strobe_n ##1 read_strobe_n [*2])
		else $error("read strobe shape wrong");
	select_held_a: assert property (
		!(write_strobe_n && read_strobe_n) |-> !chip_enable_n)
		else $error("strobe without chip enable");
	idle_free_a: assert property (op_ready |-> chip_enable_n) else $error("ce low idle");
	done_ready_a: assert property (op_done |-> $past(ready_busy_n)) else $error("done busy");
	addr_drive_a: assert property ($rose(ale) |-> io_oe) else $error("address not driven");
	read_float_a: assert property (!read_strobe_n |-> !io_oe) else $error("bus fight");
	wp_high_a: assert property (write_protect_n) else $error("write protect dropped");
	cover property ($fell(read_strobe_n));
	cover property (!ready_busy_n ##1 ready_busy_n);
	cover property (op_done ##1 !op_ready);
endmodule

bind nrps_host nrps_host_asserts u_nrps_host_asserts (
	.mclk(mclk), .reset(reset), .op_ready(op_ready), .op_done(op_done), .cle(cle), .ale(ale),
	.chip_enable_n(chip_enable_n), .write_strobe_n(write_strobe_n),
	.read_strobe_n(read_strobe_n), .write_protect_n(write_protect_n),
	.ready_busy_n(ready_busy_n), .io_oe(io_oe)
);

// [verification/nrps_nand_model.sv]
// behavioural nand device facing the host sequencer
module nrps_nand_model (
	// clock
	input wire logic mclk,
	// pins from host
	input wire logic chip_enable_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic [7:0] io_out,
	// test control and answers
	input wire logic fail_inject,
	output logic ready_busy_n,
	output logic [7:0] dout
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cmd = 8'h00;
	logic [7:0] adr [5];
	logic [2:0] acnt = 3'h0;
	logic [12:0] col = 13'h0000;
	logic [16:0] page = 17'h00000;
	logic [7:0] mem [16];
	logic [7:0] last = 8'h00;
	logic [7:0] rbyte;
	logic fail = 1'b0;
	logic go = 1'b0;
	logic go_q = 1'b0;
	logic [4:0] bcnt = 5'h00;
	// busy shows at once after a start command, then counts down
	assign ready_busy_n = (bcnt == 5'h00) && (go == go_q);
	assign rbyte = (cmd == 8'h70) ? {7'h70, fail} : (col[7:0] ^ page[7:0]);
	assign dout = (!read_strobe_n && !chip_enable_n) ? rbyte : ~last;
	always @(posedge mclk) begin
		go_q <= go;
		bcnt <= (go != go_q) ? 5'h10 : bcnt - {4'h0, bcnt != 5'h00};
	end
	// commands decode even while busy
	always @(posedge write_strobe_n) begin
		if (!chip_enable_n && cle) begin
			cmd <= io_out;
			acnt <= 3'h0;
			if (io_out == 8'h80) fail <= 1'b0;
			if (io_out == 8'h30) go <= ~go;
			if (io_out == 8'h31 || io_out == 8'h3F) begin
				page <= page + 17'h00001;
				col <= 13'h0000;
				go <= ~go;
			end
			if (io_out == 8'h10 || io_out == 8'h11) begin
				fail <= fail | fail_inject;
				go <= ~go;
			end
		end else if (!chip_enable_n && ale) begin
			adr[acnt] <= io_out;
			acnt <= acnt + 3'h1;
			if (acnt == 3'h1) col <= {io_out[4:0], adr[0]};
			if (acnt == 3'h4) page <= {io_out[0], adr[3], adr[2]};
		end else if (!chip_enable_n) begin
			mem[col[3:0]] <= io_out;
			col <= col + 13'h0001;
		end
	end
	always @(posedge read_strobe_n) begin
		last <= rbyte;
		if (cmd != 8'h70) col <= col + 13'h0001;
	end
endmodule

// [verification/tb.sv]
// self-checking bench for the nand host sequencer
`define CHK_EQ(a, b) total_checks++; if ((a) !== (b)) begin num_errors++; $display("mismatch at %0t: got %h want %h", $time, a, b); end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import nrps_pkg::*;
	logic mclk = 1'b0, reset = 1'b1, op_valid = 1'b0, op_skip_read_cmd = 1'b0, fail_inject = 1'b0;
	nrps_op_type op_code = NRPS_OP_READ;
	logic [12:0] op_column = 13'h0000;
	logic [16:0] op_page = 17'h00000, op_page2 = 17'h00000;
	logic [7:0] op_wdata = 8'h00;
	logic op_ready, op_done, op_error, any_page_failed, cle, ale, chip_enable_n, io_oe;
	logic write_strobe_n, read_strobe_n, write_protect_n, ready_busy_n;
	logic [7:0] op_rdata, io_out, io_in, m_dout;
	int num_errors = 0, total_checks = 0;
	assign io_in = io_oe ? io_out : m_dout;
	initial forever #10 mclk = ~mclk;
	nrps_host u_nrps_host (.mclk(mclk), .reset(reset), .op_valid(op_valid), .op_ready(op_ready),
		.op_code(op_code), .op_column(op_column), .op_page(op_page), .op_page2(op_page2),
		.op_wdata(op_wdata), .op_skip_read_cmd(op_skip_read_cmd), .op_done(op_done),
		.op_rdata(op_rdata), .op_error(op_error), .any_page_failed(any_page_failed), .cle(cle),
		.ale(ale), .chip_enable_n(chip_enable_n), .write_strobe_n(write_strobe_n),
		.read_strobe_n(read_strobe_n), .write_protect_n(write_protect_n),
		.ready_busy_n(ready_busy_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
	nrps_nand_model u_nrps_nand_model (.mclk(mclk), .chip_enable_n(chip_enable_n), .cle(cle),
		.ale(ale), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
		.io_out(io_out), .fail_inject(fail_inject), .ready_busy_n(ready_busy_n), .dout(m_dout));
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// one user operation, waiting for its done pulse
	task automatic run(nrps_op_type c, logic [12:0] cl, logic [16:0] p, logic [16:0] p2,
		logic [7:0] wd);
		int n;
		n = 0;
		while (op_ready !== 1'b1) begin
			@(posedge mclk);
			#1;
		end
		{op_code, op_column, op_page, op_page2, op_wdata} = {c, cl, p, p2, wd};
		op_valid = 1'b1;
		@(posedge mclk);
		#1;
		op_valid = 1'b0;
		while (op_done !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		`CHK_EQ(n < 3000, 1'b1)
	endtask
	task automatic t_power_read();
		op_skip_read_cmd = 1'b1;
		run(NRPS_OP_READ, 13'h0005, 17'h00041, 17'h00000, 8'h00);
		op_skip_read_cmd = 1'b0;
		`CHK_EQ(op_error, 1'b0)
		run(NRPS_OP_READ_DATA, 13'h0000, 17'h00000, 17'h00000, 8'h00);
		`CHK_EQ(op_rdata, 8'h05 ^ 8'h41)
		run(NRPS_OP_READ_DATA, 13'h0000, 17'h00000, 17'h00000, 8'h00);
		`CHK_EQ(op_rdata, 8'h06 ^ 8'h41)
		$display("test power_read done");
	endtask
	task automatic t_cache();
		run(NRPS_OP_READ, 13'h0002, 17'h00080, 17'h00000, 8'h00);
		run(NRPS_OP_CACHE_NEXT, 13'h0000, 17'h00080, 17'h00000, 8'h00);
		`CHK_EQ(op_error, 1'b0)
		run(NRPS_OP_READ_DATA, 13'h0000, 17'h00000, 17'h00000, 8'h00);
		`CHK_EQ(op_rdata, 8'h81)
		run(NRPS_OP_CACHE_LAST, 13'h0000, 17'h00080, 17'h00000, 8'h00);
		run(NRPS_OP_READ_DATA, 13'h0000, 17'h00000, 17'h00000, 8'h00);
		`CHK_EQ(op_rdata, 8'h82)
		run(NRPS_OP_READ, 13'h0000, 17'h00100, 17'h00000, 8'h00);
		`CHK_EQ(op_error, 1'b0)
		run(NRPS_OP_CACHE_NEXT, 13'h0000, 17'h00080, 17'h00000, 8'h00);
		`CHK_EQ(op_error, 1'b1)
		$display("test cache done");
	endtask
	task automatic t_mp_read();
		run(NRPS_OP_MP_READ, 13'h0000, 17'h00041, 17'h00081, 8'h00);
		`CHK_EQ(op_error, 1'b0)
		`CHK_EQ(u_nrps_nand_model.page, 17'h00081)
		run(NRPS_OP_MP_READ, 13'h0000, 17'h00081, 17'h000C1, 8'h00);
		`CHK_EQ(op_error, 1'b0)
		run(NRPS_OP_MP_READ, 13'h0000, 17'h00041, 17'h000C1, 8'h00);
		`CHK_EQ(op_error, 1'b1)
		run(NRPS_OP_MP_READ, 13'h0000, 17'h00041, 17'h00082, 8'h00);
		`CHK_EQ(op_error, 1'b1)
		$display("test mp_read done");
	endtask
	task automatic t_program();
		run(NRPS_OP_PROGRAM, 13'h0000, 17'h00200, 17'h00000, 8'h00);
		run(NRPS_OP_WRITE_DATA, 13'h0000, 17'h00000, 17'h00000, 8'hA5);
		run(NRPS_OP_COL_CHANGE, 13'h0008, 17'h00000, 17'h00000, 8'h00);
		run(NRPS_OP_WRITE_DATA, 13'h0000, 17'h00000, 17'h00000, 8'h3C);
		run(NRPS_OP_COL_CHANGE, 13'h000C, 17'h00000, 17'h00000, 8'h00);
		run(NRPS_OP_WRITE_DATA, 13'h0000, 17'h00000, 17'h00000, 8'hC3);
		run(NRPS_OP_MP_PROGRAM, 13'h0000, 17'h00000, 17'h00000, 8'h00);
		`CHK_EQ(u_nrps_nand_model.mem[0], 8'hA5)
		`CHK_EQ(u_nrps_nand_model.mem[8], 8'h3C)
		`CHK_EQ(u_nrps_nand_model.mem[12], 8'hC3)
		`CHK_EQ(u_nrps_nand_model.cmd, 8'h11)
		run(NRPS_OP_PROGRAM, 13'h0000, 17'h00240, 17'h00000, 8'h00);
		run(NRPS_OP_MP_PROGRAM, 13'h0000, 17'h00000, 17'h00000, 8'h00);
		`CHK_EQ(u_nrps_nand_model.cmd, 8'h10)
		run(NRPS_OP_STATUS, 13'h0000, 17'h00000, 17'h00000, 8'h00);
		`CHK_EQ(any_page_failed, 1'b0)
		$display("test program done");
	endtask
	task automatic t_multi_prog();
		run(NRPS_OP_PROGRAM, 13'h0000, 17'h00040, 17'h00000, 8'h00);
		run(NRPS_OP_WRITE_DATA, 13'h0000, 17'h00000, 17'h00000, 8'h11);
		fail_inject = 1'b1;
		run(NRPS_OP_MP_PROGRAM, 13'h0000, 17'h00000, 17'h00000, 8'h00);
		fail_inject = 1'b0;
		`CHK_EQ(u_nrps_nand_model.cmd, 8'h11)
		run(NRPS_OP_READ, 13'h0000, 17'h00040, 17'h00000, 8'h00);
		`CHK_EQ(op_error, 1'b1)
		run(NRPS_OP_STATUS, 13'h0000, 17'h00000, 17'h00000, 8'h00);
		`CHK_EQ(op_error, 1'b0)
		run(NRPS_OP_PROGRAM, 13'h0000, 17'h00080, 17'h00000, 8'h00);
		run(NRPS_OP_WRITE_DATA, 13'h0000, 17'h00000, 17'h00000, 8'h22);
		run(NRPS_OP_MP_PROGRAM, 13'h0000, 17'h00000, 17'h00000, 8'h00);
		`CHK_EQ(u_nrps_nand_model.cmd, 8'h10)
		run(NRPS_OP_STATUS, 13'h0000, 17'h00000, 17'h00000, 8'h00);
		`CHK_EQ(any_page_failed, 1'b1)
		run(NRPS_OP_RESET, 13'h0000, 17'h00000, 17'h00000, 8'h00);
		`CHK_EQ(u_nrps_nand_model.cmd, 8'hFF)
		`CHK_EQ(op_error, 1'b0)
		$display("test multi_prog done");
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		results();
	end
	initial begin
		repeat (12) @(posedge mclk);
		#1;
		reset = 1'b0;
		t_power_read();
		t_cache();
		t_mp_read();
		t_program();
		t_multi_prog();
		results();
	end
endmodule
